// ---- include/dual_uart_bus_map.svh ----
// constants of the dual channel host bus port: offsets, fields, timing
// assumes the includer has a 4 ns system clock
`ifndef DUAL_UART_BUS_MAP_SVH
`define DUAL_UART_BUS_MAP_SVH

// register offsets inside one channel
`define REG_DATA 3'h0
`define REG_TX_COUNT 3'h1
`define REG_RX_COUNT 3'h2
`define REG_SCRATCH 3'h3
`define REG_MODEM_CTRL 3'h4
`define REG_STATUS 3'h5

// modem control field that gates irq and general-purpose output
`define MCR_OUT_BIT 3
`define MCR_RESET 8'h00
`define SCRATCH_RESET 8'h00

// fifo shape
`define FIFO_DEPTH 16
`define FIFO_PTR_W 4

// pin synchroniser width and idle level (selects, strobes high)
`define SYNC_W 15
`define SYNC_RESET 15'h7fff
`define BUS_IDLE 8'hff

// host bus timing
`define CLK_NS 4
`define SETUP_NS 8
`define STROBE_NS 32
`define HOLD_NS 8
`define RECOVER_NS 16
`define SETUP_CYCLES ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_CYCLES ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_CYCLES ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOVER_CYCLES ((`RECOVER_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- include/dual_uart_bus_pkg.sv ----
// types shared by both ends of the dual channel host bus port
// assumes nothing beyond a SystemVerilog compiler
package dual_uart_bus_pkg;
  typedef enum logic [2:0] {
    HOST_IDLE,
    HOST_SETUP,
    HOST_STROBE,
    HOST_HOLD,
    HOST_RECOVER
  } host_state_type;
endpackage

// ---- include/uart_bus_if.sv ----
// pin carrier between the host processor end and the dual channel device
// assumes the testbench instantiates it and hands the modports to both ends
`timescale 1ns/1ps
`default_nettype none
`include "dual_uart_bus_map.svh"
interface uart_bus_if;
  logic chan_a_sel_n;
  logic chan_b_sel_n;
  logic [2:0] reg_addr;
  logic read_strobe_n;
  logic write_strobe_n;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic [7:0] data_bus;
  logic chan_a_irq;
  logic chan_a_irq_oe;
  logic chan_b_irq;
  logic chan_b_irq_oe;
  logic chan_a_irq_level;
  logic chan_b_irq_level;
  logic chan_a_gp_out_n;
  logic chan_b_gp_out_n;
  logic chan_a_tx_ready_n;
  logic chan_b_tx_ready_n;
  logic chan_a_rx_ready_n;
  logic chan_b_rx_ready_n;

  // wire levels; an undriven data bus floats high, an undriven irq low
  assign data_bus = dev_data_oe ? dev_data :
                    (host_data_oe ? host_data : `BUS_IDLE);
  assign chan_a_irq_level = chan_a_irq_oe & chan_a_irq;
  assign chan_b_irq_level = chan_b_irq_oe & chan_b_irq;

  modport device (
    input chan_a_sel_n, chan_b_sel_n, reg_addr, read_strobe_n,
    input write_strobe_n, data_bus,
    output dev_data, dev_data_oe, chan_a_irq, chan_a_irq_oe,
    output chan_b_irq, chan_b_irq_oe, chan_a_gp_out_n, chan_b_gp_out_n,
    output chan_a_tx_ready_n, chan_b_tx_ready_n,
    output chan_a_rx_ready_n, chan_b_rx_ready_n
  );
  modport host (
    output chan_a_sel_n, chan_b_sel_n, reg_addr, read_strobe_n,
    output write_strobe_n, host_data, host_data_oe,
    input data_bus, chan_a_irq_level, chan_b_irq_level,
    input chan_a_tx_ready_n, chan_b_tx_ready_n,
    input chan_a_rx_ready_n, chan_b_rx_ready_n
  );
endinterface
`default_nettype wire

// ---- hw/dual_uart_bus_device.sv ----
// device end of the dual channel host bus port with per-channel fifos
// assumes host pins arrive asynchronously; user side shares sys_clk
// Functional notes
// - three-bit address picks a channel register
// - eight-bit bus, driven on reads, sampled writes
// - read strobe fall fetches the addressed byte
// - byte held on bus until read strobe rises
// - write loads bus byte at strobe rise
// - channel A responds only while selected
// - channel B responds only while selected
// - modem bit set: irq A driven, gp low
// - modem bit clear: irq A floats, gp high
// - channel B irq and gp follow its bit
// - active-low transmit ready per channel
// - active-low receive ready per channel
// - two channels, sixteen-byte fifos each way
`timescale 1ns/1ps
`default_nettype none
`include "dual_uart_bus_map.svh"
module dual_uart_bus_device #(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int PTR_W = `FIFO_PTR_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // host bus pins
  uart_bus_if.device bus,
  // transmit drain, one lane per channel (0 = A)
  input wire logic [1:0] tx_pop,
  output logic [1:0][7:0] tx_byte,
  output logic [1:0] tx_byte_valid,
  // receive fill, one lane per channel
  input wire logic [1:0] rx_push,
  input wire logic [1:0][7:0] rx_byte,
  output logic [1:0] rx_dropped
);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  logic [`SYNC_W-1:0] pins_raw;
  logic [`SYNC_W-1:0] sync_1_reg;
  logic [`SYNC_W-1:0] sync_1_next;
  logic [`SYNC_W-1:0] sync_2_reg;
  logic [`SYNC_W-1:0] sync_2_next;
  logic rd_prev_reg;
  logic rd_prev_next;
  logic wr_prev_reg;
  logic wr_prev_next;
  logic [1:0] acc_sel_reg;
  logic [1:0] acc_sel_next;
  logic [2:0] acc_addr_reg;
  logic [2:0] acc_addr_next;
  logic [7:0] wr_data_reg;
  logic [7:0] wr_data_next;
  logic [7:0] dout_reg;
  logic [7:0] dout_next;
  logic doe_reg;
  logic doe_next;
  logic [1:0] sel_s;
  logic rd_s_n;
  logic wr_s_n;
  logic [2:0] addr_s;
  logic [7:0] data_s;
  logic rd_fall;
  logic wr_fall;
  logic wr_rise;
  logic [1:0] rd_go;
  logic [1:0] wr_go;
  logic [1:0][7:0] fetch;

  assign pins_raw = {bus.chan_b_sel_n, bus.chan_a_sel_n, bus.read_strobe_n,
                     bus.write_strobe_n, bus.reg_addr, bus.data_bus};
  assign sel_s = ~sync_2_reg[14:13];
  assign rd_s_n = sync_2_reg[12];
  assign wr_s_n = sync_2_reg[11];
  assign addr_s = sync_2_reg[10:8];
  assign data_s = sync_2_reg[7:0];
  // a strobe falling while the other is low starts no access; wr_rise does not look at the read strobe
  assign rd_fall = rd_prev_reg & ~rd_s_n & wr_s_n;
  assign wr_fall = wr_prev_reg & ~wr_s_n & rd_s_n;
  assign wr_rise = ~wr_prev_reg & wr_s_n;
  assign rd_go = rd_fall ? sel_s : 2'h0;
  // select must still be seen at the rising edge, else the write is lost
  assign wr_go = wr_rise ? (acc_sel_reg & sel_s) : 2'h0;

  always_comb
  begin
    sync_1_next = pins_raw;
    sync_2_next = sync_1_reg;
    rd_prev_next = rd_s_n;
    wr_prev_next = wr_s_n;
    acc_sel_next = acc_sel_reg;
    acc_addr_next = acc_addr_reg;
    wr_data_next = wr_data_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    if (rd_fall || wr_fall)
    begin
      acc_sel_next = sel_s;
      acc_addr_next = addr_s;
    end
    // keep the last byte seen while the strobe is low
    if (!wr_s_n && rd_s_n)
    begin
      wr_data_next = data_s;
    end
    if (rd_s_n || sel_s == 2'h0)
    begin
      doe_next = 1'b0;
    end
    else if (rd_fall)
    begin
      // channel A wins if the host selects both
      dout_next = sel_s[0] ? fetch[0] : fetch[1];
      doe_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_1_reg <= `SYNC_RESET;
      sync_2_reg <= `SYNC_RESET;
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
      acc_sel_reg <= 2'h0;
      acc_addr_reg <= 3'h0;
      wr_data_reg <= 8'h00;
      dout_reg <= 8'h00;
      doe_reg <= 1'b0;
    end
    else
    begin
      sync_1_reg <= sync_1_next;
      sync_2_reg <= sync_2_next;
      rd_prev_reg <= rd_prev_next;
      wr_prev_reg <= wr_prev_next;
      acc_sel_reg <= acc_sel_next;
      acc_addr_reg <= acc_addr_next;
      wr_data_reg <= wr_data_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
    end
  end

  assign bus.dev_data = dout_reg;
  assign bus.dev_data_oe = doe_reg;

  // one independent channel per lane
  for (genvar g = 0; g < 2; g++)
  begin : chan
    logic [7:0] tx_mem [DEPTH];
    logic [7:0] rx_mem [DEPTH];
    logic [7:0] mcr_reg, mcr_next;
    logic [7:0] scratch_reg, scratch_next;
    logic [PTR_W-1:0] tx_wp_reg, tx_wp_next, tx_rp_reg, tx_rp_next;
    logic [PTR_W-1:0] rx_wp_reg, rx_wp_next, rx_rp_reg, rx_rp_next;
    logic [CNT_W-1:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
    logic [7:0] txb_reg, txb_next;
    logic txv_reg, txv_next, drop_reg, drop_next;
    logic irq_reg, irq_next, irq_oe_reg, irq_oe_next;
    logic gp_n_reg, gp_n_next, txr_n_reg, txr_n_next;
    logic rxr_n_reg, rxr_n_next;
    logic [7:0] fetch_byte;
    logic tx_push, tx_take, rx_put, rx_take, tx_full, rx_full;

    assign tx_full = (tx_cnt_reg == FULL_CNT);
    assign rx_full = (rx_cnt_reg == FULL_CNT);
    assign tx_push = wr_go[g] && acc_addr_reg == `REG_DATA && !tx_full;
    assign tx_take = tx_pop[g] && tx_cnt_reg != '0;
    assign rx_put = rx_push[g] && !rx_full;
    // a read of the data register pops one received byte
    assign rx_take = rd_go[g] && addr_s == `REG_DATA && rx_cnt_reg != '0;

    always_comb
    begin
      case (addr_s)
        `REG_DATA: fetch_byte = (rx_cnt_reg != '0) ? rx_mem[rx_rp_reg]
                                                   : 8'h00;
        `REG_TX_COUNT: fetch_byte = 8'(tx_cnt_reg);
        `REG_RX_COUNT: fetch_byte = 8'(rx_cnt_reg);
        `REG_SCRATCH: fetch_byte = scratch_reg;
        `REG_MODEM_CTRL: fetch_byte = mcr_reg;
        `REG_STATUS: fetch_byte = {4'h0, rx_full, rx_cnt_reg != '0,
                                   tx_full, tx_cnt_reg == '0};
        default: fetch_byte = 8'h00;
      endcase
    end
    assign fetch[g] = fetch_byte;

    always_comb
    begin
      mcr_next = mcr_reg;
      scratch_next = scratch_reg;
      if (wr_go[g] && acc_addr_reg == `REG_MODEM_CTRL)
      begin
        mcr_next = wr_data_reg;
      end
      if (wr_go[g] && acc_addr_reg == `REG_SCRATCH)
      begin
        scratch_next = wr_data_reg;
      end
      tx_wp_next = tx_push ? tx_wp_reg + PTR_W'(1) : tx_wp_reg;
      tx_rp_next = tx_take ? tx_rp_reg + PTR_W'(1) : tx_rp_reg;
      rx_wp_next = rx_put ? rx_wp_reg + PTR_W'(1) : rx_wp_reg;
      rx_rp_next = rx_take ? rx_rp_reg + PTR_W'(1) : rx_rp_reg;
      tx_cnt_next = tx_cnt_reg + CNT_W'(tx_push) - CNT_W'(tx_take);
      rx_cnt_next = rx_cnt_reg + CNT_W'(rx_put) - CNT_W'(rx_take);
      txb_next = tx_take ? tx_mem[tx_rp_reg] : txb_reg;
      txv_next = tx_take;
      drop_next = rx_push[g] && rx_full;
      // pins are computed from next state so they track without lag
      irq_next = (rx_cnt_next != '0);
      irq_oe_next = mcr_next[`MCR_OUT_BIT];
      gp_n_next = ~mcr_next[`MCR_OUT_BIT];
      txr_n_next = (tx_cnt_next == FULL_CNT);
      rxr_n_next = (rx_cnt_next == '0);
    end

    // fifo storage carries no reset; the pointers define what is valid
    always_ff @(posedge sys_clk)
    begin
      if (tx_push)
      begin
        tx_mem[tx_wp_reg] <= wr_data_reg;
      end
      if (rx_put)
      begin
        rx_mem[rx_wp_reg] <= rx_byte[g];
      end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        mcr_reg <= `MCR_RESET;
        scratch_reg <= `SCRATCH_RESET;
        tx_wp_reg <= '0;
        tx_rp_reg <= '0;
        rx_wp_reg <= '0;
        rx_rp_reg <= '0;
        tx_cnt_reg <= '0;
        rx_cnt_reg <= '0;
        txb_reg <= 8'h00;
        txv_reg <= 1'b0;
        drop_reg <= 1'b0;
        irq_reg <= 1'b0;
        irq_oe_reg <= 1'b0;
        gp_n_reg <= 1'b1;
        txr_n_reg <= 1'b0;
        rxr_n_reg <= 1'b1;
      end
      else
      begin
        mcr_reg <= mcr_next;
        scratch_reg <= scratch_next;
        tx_wp_reg <= tx_wp_next;
        tx_rp_reg <= tx_rp_next;
        rx_wp_reg <= rx_wp_next;
        rx_rp_reg <= rx_rp_next;
        tx_cnt_reg <= tx_cnt_next;
        rx_cnt_reg <= rx_cnt_next;
        txb_reg <= txb_next;
        txv_reg <= txv_next;
        drop_reg <= drop_next;
        irq_reg <= irq_next;
        irq_oe_reg <= irq_oe_next;
        gp_n_reg <= gp_n_next;
        txr_n_reg <= txr_n_next;
        rxr_n_reg <= rxr_n_next;
      end
    end

    assign tx_byte[g] = txb_reg;
    assign tx_byte_valid[g] = txv_reg;
    assign rx_dropped[g] = drop_reg;
  end

  assign bus.chan_a_irq = chan[0].irq_reg;
  assign bus.chan_a_irq_oe = chan[0].irq_oe_reg;
  assign bus.chan_a_gp_out_n = chan[0].gp_n_reg;
  assign bus.chan_a_tx_ready_n = chan[0].txr_n_reg;
  assign bus.chan_a_rx_ready_n = chan[0].rxr_n_reg;
  assign bus.chan_b_irq = chan[1].irq_reg;
  assign bus.chan_b_irq_oe = chan[1].irq_oe_reg;
  assign bus.chan_b_gp_out_n = chan[1].gp_n_reg;
  assign bus.chan_b_tx_ready_n = chan[1].txr_n_reg;
  assign bus.chan_b_rx_ready_n = chan[1].rxr_n_reg;
endmodule
`default_nettype wire

// ---- hw/dual_uart_bus_host.sv ----
// host processor end: turns one user request into one strobed bus cycle
// assumes the device end shares sys_clk; device pins are read directly
`timescale 1ns/1ps
`default_nettype none
`include "dual_uart_bus_map.svh"
module dual_uart_bus_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // host bus pins
  uart_bus_if.host bus,
  // request from user logic
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_chan,
  input wire logic [2:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  // answer to user logic
  output logic resp_valid,
  output logic [7:0] resp_rdata,
  // device status pins, lane 0 = channel A, 1 = active
  output logic [1:0] irq_seen,
  output logic [1:0] tx_ready,
  output logic [1:0] rx_ready
);
  dual_uart_bus_pkg::host_state_type state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [1:0] sel_n_reg, sel_n_next;
  logic [2:0] addr_reg, addr_next;
  logic rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
  logic write_reg, write_next;
  logic [7:0] hdata_reg, hdata_next;
  logic hoe_reg, hoe_next;
  logic ready_reg, ready_next;
  logic rv_reg, rv_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] irq_reg, txr_reg, rxr_reg;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
    sel_n_next = sel_n_reg;
    addr_next = addr_reg;
    rd_n_next = rd_n_reg;
    wr_n_next = wr_n_reg;
    write_next = write_reg;
    hdata_next = hdata_reg;
    hoe_next = hoe_reg;
    ready_next = ready_reg;
    rv_next = 1'b0;
    rdata_next = rdata_reg;
    case (state_reg)
      dual_uart_bus_pkg::HOST_IDLE:
      begin
        if (req_valid && ready_reg)
        begin
          sel_n_next = req_chan ? 2'b01 : 2'b10;
          addr_next = req_addr;
          write_next = req_write;
          hdata_next = req_wdata;
          hoe_next = req_write;
          ready_next = 1'b0;
          cnt_next = 8'(`SETUP_CYCLES - 1);
          state_next = dual_uart_bus_pkg::HOST_SETUP;
        end
      end
      dual_uart_bus_pkg::HOST_SETUP:
      begin
        if (cnt_reg == 8'h00)
        begin
          // only one strobe ever goes low
          rd_n_next = write_reg;
          wr_n_next = ~write_reg;
          cnt_next = 8'(`STROBE_CYCLES - 1);
          state_next = dual_uart_bus_pkg::HOST_STROBE;
        end
      end
      dual_uart_bus_pkg::HOST_STROBE:
      begin
        if (cnt_reg == 8'h00)
        begin
          rd_n_next = 1'b1;
          wr_n_next = 1'b1;
          rv_next = 1'b1;
          if (!write_reg)
          begin
            rdata_next = bus.data_bus;
          end
          cnt_next = 8'(`HOLD_CYCLES - 1);
          state_next = dual_uart_bus_pkg::HOST_HOLD;
        end
      end
      dual_uart_bus_pkg::HOST_HOLD:
      begin
        // select, address and data outlast the strobe
        if (cnt_reg == 8'h00)
        begin
          sel_n_next = 2'b11;
          hoe_next = 1'b0;
          cnt_next = 8'(`RECOVER_CYCLES - 1);
          state_next = dual_uart_bus_pkg::HOST_RECOVER;
        end
      end
      dual_uart_bus_pkg::HOST_RECOVER:
      begin
        if (cnt_reg == 8'h00)
        begin
          ready_next = 1'b1;
          state_next = dual_uart_bus_pkg::HOST_IDLE;
        end
      end
      default:
      begin
        state_next = dual_uart_bus_pkg::HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= dual_uart_bus_pkg::HOST_IDLE;
      cnt_reg <= 8'h00;
      sel_n_reg <= 2'b11;
      addr_reg <= 3'h0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      write_reg <= 1'b0;
      hdata_reg <= 8'h00;
      hoe_reg <= 1'b0;
      ready_reg <= 1'b1;
      rv_reg <= 1'b0;
      rdata_reg <= 8'h00;
      irq_reg <= 2'h0;
      txr_reg <= 2'h0;
      rxr_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sel_n_reg <= sel_n_next;
      addr_reg <= addr_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      write_reg <= write_next;
      hdata_reg <= hdata_next;
      hoe_reg <= hoe_next;
      ready_reg <= ready_next;
      rv_reg <= rv_next;
      rdata_reg <= rdata_next;
      irq_reg <= {bus.chan_b_irq_level, bus.chan_a_irq_level};
      txr_reg <= ~{bus.chan_b_tx_ready_n, bus.chan_a_tx_ready_n};
      rxr_reg <= ~{bus.chan_b_rx_ready_n, bus.chan_a_rx_ready_n};
    end
  end

  assign bus.chan_a_sel_n = sel_n_reg[0];
  assign bus.chan_b_sel_n = sel_n_reg[1];
  assign bus.reg_addr = addr_reg;
  assign bus.read_strobe_n = rd_n_reg;
  assign bus.write_strobe_n = wr_n_reg;
  assign bus.host_data = hdata_reg;
  assign bus.host_data_oe = hoe_reg;
  assign req_ready = ready_reg;
  assign resp_valid = rv_reg;
  assign resp_rdata = rdata_reg;
  assign irq_seen = irq_reg;
  assign tx_ready = txr_reg;
  assign rx_ready = rxr_reg;
endmodule
`default_nettype wire

// ---- sim/dual_uart_bus_properties.sv ----
// assertions on the host bus pins between host end and device end
// assumes one sys_clk domain; signals come straight from the interface
`timescale 1ns/1ps
`default_nettype none
module dual_uart_bus_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // host driven pins
  input wire logic chan_a_sel_n,
  input wire logic chan_b_sel_n,
  input wire logic [2:0] reg_addr,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic host_data_oe,
  // device driven pins
  input wire logic [7:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic chan_a_irq_oe,
  input wire logic chan_b_irq_oe,
  input wire logic chan_a_gp_out_n,
  input wire logic chan_b_gp_out_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic sel_any;
  logic strobe_on;
  assign sel_any = !(chan_a_sel_n && chan_b_sel_n);
  assign strobe_on = !(read_strobe_n && write_strobe_n);

  a_gp_mirror_a: assert property (chan_a_gp_out_n != chan_a_irq_oe)
    else $error("gp output A does not mirror irq enable A");
  a_gp_mirror_b: assert property (chan_b_gp_out_n != chan_b_irq_oe)
    else $error("gp output B does not mirror irq enable B");
  // two sync flops plus the fetch register
  a_read_fetch: assert property (
    $fell(read_strobe_n) && sel_any && write_strobe_n |-> ##[2:4] dev_data_oe)
    else $error("read strobe fall did not drive the bus");
  a_read_hold: assert property (
    dev_data_oe && !read_strobe_n |=> dev_data_oe && $stable(dev_data))
    else $error("read byte not held while strobe low");
  a_idle_release: assert property (read_strobe_n [*5] |-> !dev_data_oe)
    else $error("bus still driven after read strobe rose");
  a_unselected_quiet: assert property ((!sel_any) [*5] |-> !dev_data_oe)
    else $error("bus driven with no channel selected");
  a_one_strobe: assert property (read_strobe_n || write_strobe_n)
    else $error("both strobes low");
  a_addr_steady: assert property (
    strobe_on && $past(strobe_on) |-> $stable(reg_addr) &&
    $stable(chan_a_sel_n) && $stable(chan_b_sel_n))
    else $error("address or select moved under strobe");
  a_write_data_driven: assert property (
    !write_strobe_n |-> host_data_oe && !dev_data_oe)
    else $error("write data not driven by host alone");

  cover property ($rose(dev_data_oe) && !chan_a_sel_n);
  cover property ($rose(write_strobe_n) && !chan_b_sel_n);
  cover property ($fell(chan_a_gp_out_n));
endmodule
`default_nettype wire

// ---- sim/dual_uart_bus_port_tb.sv ----
// self-checking bench: host end and device end joined by the interface
// assumes the interface, both ends and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dual_uart_bus_map.svh"
module dual_uart_bus_port_tb;
  logic sys_clk, nrst;
  logic req_valid, req_write, req_chan, req_ready, resp_valid;
  logic [2:0] req_addr;
  logic [7:0] req_wdata, resp_rdata, rd;
  logic [1:0] irq_seen, tx_ready, rx_ready, tx_pop, rx_push;
  logic [1:0] tx_byte_valid, rx_dropped;
  logic [1:0][7:0] tx_byte, rx_byte;
  int mismatches, num_checks;

  uart_bus_if bus_if ();
  dual_uart_bus_device dual_uart_bus_device_i (.sys_clk(sys_clk),
    .nrst(nrst), .bus(bus_if), .tx_pop(tx_pop), .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid), .rx_push(rx_push), .rx_byte(rx_byte),
    .rx_dropped(rx_dropped));
  dual_uart_bus_host dual_uart_bus_host_i (.sys_clk(sys_clk), .nrst(nrst),
    .bus(bus_if), .req_valid(req_valid), .req_write(req_write),
    .req_chan(req_chan), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .irq_seen(irq_seen), .tx_ready(tx_ready),
    .rx_ready(rx_ready));
  dual_uart_bus_properties dual_uart_bus_properties_i (.sys_clk(sys_clk),
    .nrst(nrst), .chan_a_sel_n(bus_if.chan_a_sel_n),
    .chan_b_sel_n(bus_if.chan_b_sel_n), .reg_addr(bus_if.reg_addr),
    .read_strobe_n(bus_if.read_strobe_n),
    .write_strobe_n(bus_if.write_strobe_n),
    .host_data_oe(bus_if.host_data_oe), .dev_data(bus_if.dev_data),
    .dev_data_oe(bus_if.dev_data_oe), .chan_a_irq_oe(bus_if.chan_a_irq_oe),
    .chan_b_irq_oe(bus_if.chan_b_irq_oe),
    .chan_a_gp_out_n(bus_if.chan_a_gp_out_n),
    .chan_b_gp_out_n(bus_if.chan_b_gp_out_n));

  always #2 sys_clk = ~sys_clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k)
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  // bounded wait on req_ready (0) or resp_valid (1); a hang ends the run
  task automatic wait_hi(input bit pick);
    int n;
    n = 0;
    while ((pick ? resp_valid : req_ready) !== 1'b1)
    begin
      tick(1);
      n++;
      if (n > 40)
      begin
        mismatches++;
        close_out();
      end
    end
  endtask

  task automatic bus(input logic wr, input logic ch, input logic [2:0] a,
                     input logic [7:0] wd);
    wait_hi(1'b0);
    req_valid = 1'h1;
    req_write = wr;
    req_chan = ch;
    req_addr = a;
    req_wdata = wd;
    tick(1);
    req_valid = 1'h0;
    wait_hi(1'b1);
    rd = resp_rdata;
  endtask

  task automatic t_modem();
    check("gp_a", 8'h01, bus_if.chan_a_gp_out_n);
    bus(1'h1, 1'h0, `REG_MODEM_CTRL, 8'h08);
    tick(5);
    check("gp_a", 8'h00, bus_if.chan_a_gp_out_n);
    check("irq_oe_a", 8'h01, bus_if.chan_a_irq_oe);
    check("gp_b", 8'h01, bus_if.chan_b_gp_out_n);
    bus(1'h0, 1'h1, `REG_MODEM_CTRL, 8'h00);
    check("mcr_b", 8'h00, rd);
    bus(1'h1, 1'h1, `REG_MODEM_CTRL, 8'h08);
    bus(1'h1, 1'h0, `REG_MODEM_CTRL, 8'h00);
    tick(5);
    check("gp_b", 8'h00, bus_if.chan_b_gp_out_n);
    check("irq_oe_b", 8'h01, bus_if.chan_b_irq_oe);
    check("irq_oe_a", 8'h00, bus_if.chan_a_irq_oe);
    bus(1'h1, 1'h1, `REG_MODEM_CTRL, 8'h00);
  endtask

  task automatic t_scratch();
    bus(1'h1, 1'h0, `REG_SCRATCH, 8'h5a);
    bus(1'h1, 1'h1, `REG_SCRATCH, 8'ha5);
    bus(1'h0, 1'h0, `REG_SCRATCH, 8'h00);
    check("scr_a", 8'h5a, rd);
    bus(1'h0, 1'h1, `REG_SCRATCH, 8'h00);
    check("scr_b", 8'ha5, rd);
    bus(1'h0, 1'h0, 3'h7, 8'h00);
    check("unmapped", 8'h00, rd);
  endtask

  // seventeenth write must be dropped, leaving exactly sixteen
  task automatic t_tx();
    for (int i = 0; i < 17; i++)
      bus(1'h1, 1'h0, `REG_DATA, 8'h10 + 8'(i));
    tick(5);
    check("txrdy_a", 8'h01, bus_if.chan_a_tx_ready_n);
    check("txrdy_b", 8'h00, bus_if.chan_b_tx_ready_n);
    check("tx_ready", 8'h02, tx_ready);
    bus(1'h0, 1'h0, `REG_STATUS, 8'h00);
    check("status_a", 8'h02, rd);
    bus(1'h0, 1'h0, `REG_TX_COUNT, 8'h00);
    check("tx_count_a", 8'(`FIFO_DEPTH), rd);
    // valid is a one-cycle pulse: look while it stands
    for (int i = 0; i < 16; i++)
    begin
      tx_pop = 2'h1;
      tick(1);
      tx_pop = 2'h0;
      check("tx_valid", 8'h01, tx_byte_valid);
      check("tx_byte", 8'h10 + 8'(i), tx_byte[0]);
      tick(1);
    end
    tick(2);
    check("txrdy_a", 8'h00, bus_if.chan_a_tx_ready_n);
    bus(1'h0, 1'h0, `REG_STATUS, 8'h00);
    check("status_a", 8'h01, rd);
  endtask

  task automatic t_rx();
    int drops;
    drops = 0;
    for (int i = 0; i < 19; i++)
    begin
      rx_push = (i < 17) ? 2'h2 : 2'h0;
      rx_byte[1] = 8'h40 + 8'(i);
      tick(1);
      if (rx_dropped[1] === 1'b1)
        drops++;
    end
    check("drops", 8'h01, 8'(drops));
    check("rxrdy_b", 8'h00, bus_if.chan_b_rx_ready_n);
    check("rxrdy_a", 8'h01, bus_if.chan_a_rx_ready_n);
    check("rx_ready", 8'h02, rx_ready);
    check("irq_b_float", 8'h00, bus_if.chan_b_irq_level);
    bus(1'h0, 1'h1, `REG_RX_COUNT, 8'h00);
    check("rx_count_b", 8'(`FIFO_DEPTH), rd);
    bus(1'h1, 1'h1, `REG_MODEM_CTRL, 8'h08);
    tick(5);
    check("irq_b", 8'h01, bus_if.chan_b_irq_level);
    check("irq_seen", 8'h02, irq_seen);
    for (int i = 0; i < 16; i++)
    begin
      bus(1'h0, 1'h1, `REG_DATA, 8'h00);
      check("rx_byte", 8'h40 + 8'(i), rd);
    end
    tick(5);
    check("rxrdy_b", 8'h01, bus_if.chan_b_rx_ready_n);
    check("irq_b", 8'h00, bus_if.chan_b_irq_level);
    bus(1'h1, 1'h1, `REG_MODEM_CTRL, 8'h00);
  endtask

  initial
  begin
    sys_clk = 1'h0;
    nrst = 1'h0;
    req_valid = 1'h0;
    req_write = 1'h0;
    req_chan = 1'h0;
    req_addr = 3'h0;
    req_wdata = 8'h00;
    tx_pop = 2'h0;
    rx_push = 2'h0;
    rx_byte = 16'h0000;
    mismatches = 0;
    num_checks = 0;
    repeat (2) @(posedge sys_clk);
    #1;
    nrst = 1'h1;
    tick(1);
    check("txrdy_a", 8'h00, bus_if.chan_a_tx_ready_n);
    check("rxrdy_a", 8'h01, bus_if.chan_a_rx_ready_n);
    t_modem();
    t_scratch();
    t_tx();
    t_rx();
    close_out();
  end
endmodule
`default_nettype wire
